// ---- src/sptu_top.sv ----
// How it works
// - User pattern repeats 32 or 2048 bits
// - PRBS orders 9, 11, 15, 20, 23, 29, 31, maximal period
// - Inverse logic flips every PRBS bit
// - All zeros or all ones patterns
// - One followed by one, three, seven zeros
// - Two ones in every eight bits
// - Preset picks inverted PRBS: PRBS23 for C3VC4, PRBS15 for containers other than C4 and C3VC4, C4 keeps its order
// - Line rate deviation against nominal STM rates
// - Pattern bits per second reported separately
// - Receiver off gives not-available measurements
// - LOS flag with level, invalid when low
// - Receiver tracking; port one never tracks two
// - TCM choice forces compatible container
`timescale 1ns/10ps
module sptu_top #(
  parameter int unsigned SEC_CYCLES_P = sptu_pkg::SEC_CYCLES
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Register port
  input wire logic [9:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Transmit payload
  input wire logic TX_SLOT,
  output logic TX_DATA,
  // Receive payload and line
  input wire logic RX_SLOT,
  input wire logic RX_DATA,
  input wire logic [7:0] RX_LINE_BITS,
  input wire logic [15:0] RX_LEVEL,
  input wire logic RX_LOW,
  input wire logic RX_LOS,
  // First port receiver settings
  input wire logic [13:0] P1_RXCFG,
  // Interrupt
  output logic IRQ
);
  import sptu_pkg::*;
  function automatic logic [30:0] taps(input logic [4:0] o);
    case (o)
      5'h09: taps = 31'h00000110;
      5'h0B: taps = 31'h00000500;
      5'h0F: taps = 31'h00006000;
      5'h14: taps = 31'h00080004;
      5'h17: taps = 31'h00420000;
      5'h1D: taps = 31'h14000000;
      default: taps = 31'h48000000;
    endcase
  endfunction : taps
  function automatic logic [31:0] cfg_fix(input logic [31:0] c);
    logic [2:0] k;
    k = c[F_CONT +: 3];
    case (c[F_TCM +: 2])
      TCM_N1VC4: if (k != C_C4 && k != C_C3VC4) k = C_C4;
      TCM_N1VC3: k = C_C3VC3;
      TCM_N2: if (k != C_C12 && k != C_C11) k = C_C12;
      default: k = c[F_CONT +: 3];
    endcase
    cfg_fix = {c[31:12], k, c[8:0]};
  endfunction : cfg_fix

  // Configuration registers
  logic [31:0] txcfg, next_txcfg, rxcfg, next_rxcfg, stat, next_stat, mask, next_mask, rdata, next_rdata;
  logic usrlen, next_usrlen;
  logic [31:0] umem [64];
  logic [31:0] eff_rx, rx_src, pre;
  logic [1:0] fol;

  always_comb begin
    pre = cfg_fix(WDATA);
    if (WDATA[F_PRESET]) begin
      pre[F_TYPE +: 3] = PT_PRBS;
      pre[F_INV] = 1'b1;
      if (pre[F_CONT +: 3] == C_C3VC4) pre[F_ORD +: 5] = ORD_VC4;
      else if (pre[F_CONT +: 3] != C_C4) pre[F_ORD +: 5] = ORD_LO;
    end
    pre[F_PRESET] = 1'b0;
    next_txcfg = (WR && ADDR == A_TXCFG) ? pre : txcfg;
    next_rxcfg = (WR && ADDR == A_RXCFG) ? {1'b0, pre[30:0]} : rxcfg;
    next_mask = (WR && ADDR == A_MASK) ? WDATA : mask;
    next_usrlen = (WR && ADDR == A_USRLEN) ? WDATA[0] : usrlen;
    fol = rxcfg[F_FOL +: 2];
    if (fol == FOL_TX) rx_src = txcfg;
    else if (fol == FOL_RX1 && rxcfg[F_PORT2]) rx_src = {18'h00000, P1_RXCFG};
    else rx_src = rxcfg;
    eff_rx = cfg_fix({rxcfg[31:14], rx_src[13:0]});
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      txcfg <= RST_TXCFG;
      rxcfg <= RST_RXCFG;
      mask <= 32'h00000000;
      usrlen <= 1'b0;
    end else begin
      txcfg <= next_txcfg;
      rxcfg <= next_rxcfg;
      mask <= next_mask;
      usrlen <= next_usrlen;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (WR && ADDR[9:8] == A_USER_HI) umem[ADDR[7:2]] <= WDATA;
  end

  // Transmit generator
  sptu_pat_e tx_type;
  logic [30:0] tx_s, next_tx_s, ordmask;
  logic [2:0] phase, next_phase;
  logic [10:0] uidx, next_uidx;
  logic next_tx_data, fb, ubit;
  assign tx_type = sptu_pat_e'(txcfg[F_TYPE +: 3]);
  always_comb begin
    ordmask = 31'h7FFFFFFF >> (5'h1F - txcfg[F_ORD +: 5]);
    fb = ^(tx_s & taps(txcfg[F_ORD +: 5]));
    ubit = umem[uidx[10:5]][uidx[4:0]];
    next_tx_s = tx_s;
    next_phase = phase;
    next_uidx = uidx;
    next_tx_data = TX_DATA;
    if (TX_SLOT) begin
      next_phase = phase + 3'h1;
      next_tx_s = ((tx_s & ordmask) == 31'h00000000) ? PRBS_SEED : {tx_s[29:0], fb};
      next_uidx = (uidx >= (usrlen ? ULEN2048 : ULEN32)) ? 11'h000 : uidx + 11'h001;
      case (tx_type)
        PT_USER: next_tx_data = ubit;
        PT_PRBS: next_tx_data = fb ^ txcfg[F_INV];
        PT_ZERO: next_tx_data = 1'b0;
        PT_ONE: next_tx_data = 1'b1;
        PT_ALT11: next_tx_data = phase[0];
        PT_ALT13: next_tx_data = (phase[1:0] == 2'h0);
        PT_ALT17: next_tx_data = (phase == 3'h0);
        PT_TWO8: next_tx_data = (phase == 3'h1) || (phase == 3'h6);
        default: next_tx_data = 1'b0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      tx_s <= PRBS_SEED;
      phase <= 3'h0;
      uidx <= 11'h000;
      TX_DATA <= 1'b0;
    end else begin
      tx_s <= next_tx_s;
      phase <= next_phase;
      uidx <= next_uidx;
      TX_DATA <= next_tx_data;
    end
  end

  // Receive checker
  sptu_pat_e rx_type;
  sptu_sync_e sync, next_sync;
  logic [30:0] rx_s, next_rx_s;
  logic [6:0] good, next_good;
  logic [3:0] bad, next_bad;
  logic [31:0] errcnt, next_errcnt;
  logic rbit, expect_bit, chk_en, err, ev_err, ev_sync;
  logic rx_on;
  assign rx_type = sptu_pat_e'(eff_rx[F_TYPE +: 3]);
  assign rx_on = rxcfg[F_RXON];
  always_comb begin
    rbit = RX_DATA ^ (rx_type == PT_PRBS && eff_rx[F_INV]);
    expect_bit = (rx_type == PT_PRBS) ? ^(rx_s & taps(eff_rx[F_ORD +: 5])) : (rx_type == PT_ONE);
    chk_en = rx_on && RX_SLOT && (rx_type == PT_PRBS || rx_type == PT_ZERO || rx_type == PT_ONE);
    err = chk_en && (rbit != expect_bit);
    next_rx_s = RX_SLOT ? {rx_s[29:0], rbit} : rx_s;
    next_sync = sync;
    next_good = good;
    next_bad = bad;
    next_errcnt = errcnt;
    ev_err = 1'b0;
    ev_sync = 1'b0;
    if (!chk_en) begin
      next_sync = chk_en || rx_on ? sync : SY_HUNT;
    end else begin
      case (sync)
        SY_HUNT: begin
          next_good = err ? 7'h00 : good + 7'h01;
          if (!err && good == SYNC_GOOD - 7'h01) next_sync = SY_LOCK;
        end
        SY_LOCK: begin
          next_bad = err ? bad + 4'h1 : 4'h0;
          if (err) begin
            next_errcnt = errcnt + 32'h00000001;
            ev_err = 1'b1;
          end
          if (err && bad == SYNC_BAD - 4'h1) begin
            next_sync = SY_HUNT;
            next_good = 7'h00;
            next_bad = 4'h0;
            ev_sync = 1'b1;
          end
        end
        default: next_sync = SY_HUNT;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      sync <= SY_HUNT;
      rx_s <= PRBS_SEED;
      good <= 7'h00;
      bad <= 4'h0;
      errcnt <= 32'h00000000;
    end else begin
      sync <= next_sync;
      rx_s <= next_rx_s;
      good <= next_good;
      bad <= next_bad;
      errcnt <= next_errcnt;
    end
  end

  // One-second rate measurement
  logic [31:0] sec_cnt, next_sec_cnt, pat_acc, next_pat_acc, pat_rate, next_pat_rate;
  logic [34:0] line_acc, next_line_acc, line_rate, next_line_rate, dev, next_dev, nom;
  logic tick, los_q, next_los_q;

  always_comb begin
    case (rxcfg[F_RATE +: 2])
      2'h0: nom = NOM_STM1;
      2'h1: nom = NOM_STM4;
      2'h2: nom = NOM_STM16;
      default: nom = NOM_STM64;
    endcase
    tick = (sec_cnt == 32'(SEC_CYCLES_P - 1));
    next_sec_cnt = tick ? 32'h00000000 : sec_cnt + 32'h00000001;
    next_line_acc = line_acc + {27'h0000000, RX_LINE_BITS};
    next_pat_acc = pat_acc + {31'h00000000, RX_SLOT};
    next_line_rate = line_rate;
    next_pat_rate = pat_rate;
    next_dev = dev;
    if (tick) begin
      next_line_rate = next_line_acc;
      next_pat_rate = next_pat_acc;
      next_dev = next_line_acc - nom;
      next_line_acc = 35'h000000000;
      next_pat_acc = 32'h00000000;
    end
    if (!rx_on) begin
      next_line_acc = 35'h000000000;
      next_pat_acc = 32'h00000000;
    end
    next_los_q = RX_LOS;
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      sec_cnt <= 32'h00000000;
      line_acc <= 35'h000000000;
      pat_acc <= 32'h00000000;
      line_rate <= 35'h000000000;
      pat_rate <= 32'h00000000;
      dev <= 35'h000000000;
      los_q <= 1'b0;
    end else begin
      sec_cnt <= next_sec_cnt;
      line_acc <= next_line_acc;
      pat_acc <= next_pat_acc;
      line_rate <= next_line_rate;
      pat_rate <= next_pat_rate;
      dev <= next_dev;
      los_q <= next_los_q;
    end
  end

  // Status, interrupt and read data
  always_comb begin
    next_stat = (WR && ADDR == A_STAT) ? stat & ~WDATA : stat;
    next_stat[S_PATERR] = next_stat[S_PATERR] | ev_err;
    next_stat[S_LOS] = next_stat[S_LOS] | (rx_on && RX_LOS && !los_q);
    next_stat[S_SEC] = next_stat[S_SEC] | tick;
    next_stat[S_SYNC] = next_stat[S_SYNC] | ev_sync;
    next_rdata = 32'h00000000;
    if (RD) begin
      case (ADDR)
        A_TXCFG: next_rdata = txcfg;
        A_RXCFG: next_rdata = rxcfg;
        A_USRLEN: next_rdata = {31'h00000000, usrlen};
        A_STAT: next_rdata = stat;
        A_MASK: next_rdata = mask;
        A_ERRCNT: next_rdata = errcnt;
        A_RATE_LO: next_rdata = rx_on ? line_rate[31:0] : NA_VAL;
        A_RATE_HI: next_rdata = rx_on ? {29'h00000000, line_rate[34:32]} : NA_VAL;
        A_DEV: next_rdata = rx_on ? dev[31:0] : NA_VAL;
        A_PATRATE: next_rdata = rx_on ? pat_rate : NA_VAL;
        A_LEVEL: next_rdata = rx_on ? {14'h0000, RX_LOS, !RX_LOW, RX_LEVEL} : NA_VAL;
        A_EFFRX: next_rdata = eff_rx;
        default: next_rdata = (ADDR[9:8] == A_USER_HI) ? umem[ADDR[7:2]] : 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      stat <= 32'h00000000;
      rdata <= 32'h00000000;
    end else begin
      stat <= next_stat;
      rdata <= next_rdata;
    end
  end

  assign RDATA = rdata;
  assign IRQ = |(stat & mask);
  a_const_zero: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    TX_SLOT && tx_type == PT_ZERO |=> !TX_DATA) else $error("zero pattern sent a one");
  a_prbs_inv: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    TX_SLOT && tx_type == PT_PRBS |=> TX_DATA == ($past(fb) ^ $past(txcfg[F_INV]))) else $error("prbs polarity");
  a_slot_hold: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !TX_SLOT |=> $stable(phase) && $stable(uidx) && $stable(TX_DATA)) else $error("advanced without slot");
  a_user_wrap: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    TX_SLOT && !usrlen && uidx == ULEN32 |=> uidx == 11'h000) else $error("user 32 wrap");
  a_alt_seven: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    TX_SLOT && tx_type == PT_ALT17 && phase == 3'h3 |=> !TX_DATA) else $error("alternating 1:7 shape");
  a_preset_vc4: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    WR && ADDR == A_TXCFG && WDATA[F_PRESET] && WDATA[F_TCM +: 2] == 2'h0 && WDATA[F_CONT +: 3] == C_C3VC4
    |=> txcfg[F_ORD +: 5] == ORD_VC4 && txcfg[F_INV] && txcfg[F_TYPE +: 3] == PT_PRBS) else $error("preset");
  a_tcm_vc3: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    txcfg[F_TCM +: 2] == TCM_N1VC3 |-> txcfg[F_CONT +: 3] == C_C3VC3) else $error("tcm structure");
  a_port1_nofol: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !rxcfg[F_PORT2] && rxcfg[F_FOL +: 2] == FOL_RX1 |-> eff_rx[13:0] == rxcfg[13:0]) else $error("port1 follows");
  a_off_na: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    RD && ADDR == A_DEV && !rx_on |=> RDATA == NA_VAL) else $error("off not N/A");
  a_err_count: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    sync == SY_LOCK && err |=> errcnt == $past(errcnt) + 32'h00000001 && stat[S_PATERR]) else $error("err count");
endmodule : sptu_top

// ---- src/sptu_pkg.sv ----
package sptu_pkg;
  // Pattern types and checker states
  typedef enum logic [2:0] {PT_USER, PT_PRBS, PT_ZERO, PT_ONE, PT_ALT11, PT_ALT13, PT_ALT17, PT_TWO8} sptu_pat_e;
  typedef enum logic {SY_HUNT, SY_LOCK} sptu_sync_e;
  // Register byte addresses
  localparam logic [9:0] A_TXCFG = 10'h000;
  localparam logic [9:0] A_RXCFG = 10'h004;
  localparam logic [9:0] A_USRLEN = 10'h008;
  localparam logic [9:0] A_STAT = 10'h00C;
  localparam logic [9:0] A_MASK = 10'h010;
  localparam logic [9:0] A_ERRCNT = 10'h014;
  localparam logic [9:0] A_RATE_LO = 10'h018;
  localparam logic [9:0] A_RATE_HI = 10'h01C;
  localparam logic [9:0] A_DEV = 10'h020;
  localparam logic [9:0] A_PATRATE = 10'h024;
  localparam logic [9:0] A_LEVEL = 10'h028;
  localparam logic [9:0] A_EFFRX = 10'h02C;
  localparam logic [1:0] A_USER_HI = 2'h1;
  // Configuration field positions
  localparam int F_TYPE = 0;
  localparam int F_ORD = 3;
  localparam int F_INV = 8;
  localparam int F_CONT = 9;
  localparam int F_TCM = 12;
  localparam int F_FOL = 14;
  localparam int F_PORT2 = 16;
  localparam int F_RXON = 17;
  localparam int F_RATE = 18;
  localparam int F_PRESET = 31;
  // Containers, monitoring, tracking, line rates
  localparam logic [2:0] C_C4 = 3'h0;
  localparam logic [2:0] C_C3VC4 = 3'h1;
  localparam logic [2:0] C_C3VC3 = 3'h2;
  localparam logic [2:0] C_C12 = 3'h3;
  localparam logic [2:0] C_C11 = 3'h4;
  localparam logic [1:0] TCM_N1VC4 = 2'h1;
  localparam logic [1:0] TCM_N1VC3 = 2'h2;
  localparam logic [1:0] TCM_N2 = 2'h3;
  localparam logic [1:0] FOL_TX = 2'h1;
  localparam logic [1:0] FOL_RX1 = 2'h2;
  localparam logic [34:0] NOM_STM1 = 35'h009450C00;
  localparam logic [34:0] NOM_STM4 = 35'h025143000;
  localparam logic [34:0] NOM_STM16 = 35'h09450C000;
  localparam logic [34:0] NOM_STM64 = 35'h251430000;
  // Preset orders and reset values
  localparam logic [4:0] ORD_VC4 = 5'h17;
  localparam logic [4:0] ORD_LO = 5'h0F;
  localparam logic [31:0] RST_TXCFG = 32'h000000B9;
  localparam logic [31:0] RST_RXCFG = 32'h000200B9;
  localparam logic [31:0] NA_VAL = 32'h80000000;
  localparam logic [30:0] PRBS_SEED = 31'h7FFFFFFF;
  localparam logic [10:0] ULEN32 = 11'h01F;
  localparam logic [10:0] ULEN2048 = 11'h7FF;
  localparam logic [6:0] SYNC_GOOD = 7'h40;
  localparam logic [3:0] SYNC_BAD = 4'h8;
  // Status bits
  localparam int S_PATERR = 0;
  localparam int S_LOS = 1;
  localparam int S_SEC = 2;
  localparam int S_SYNC = 3;
  // Measurement gate
  localparam int GATE_S = 1;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SEC_CYCLES = GATE_S * (1000000000 / CLK_PERIOD_NS);
endpackage : sptu_pkg

// ---- dv/sptu_line_model.sv ----
`timescale 1ns/10ps
module sptu_line_model #(
  parameter logic [15:0] LEVEL_CODE = 16'h1234,
  parameter logic [7:0] LINE_BITS = 8'h08
) (
  // Clock and near end
  input wire logic clk,
  input wire logic tx_slot,
  input wire logic tx_data,
  // Test controls
  input wire logic inj_err,
  input wire logic los_req,
  // Far end returns
  output logic rx_slot,
  output logic rx_data,
  output logic [7:0] line_bits,
  output logic [15:0] level,
  output logic rx_low,
  output logic rx_los
);
  logic slot_d;
  initial begin
    slot_d = 1'b0;
    rx_slot = 1'b0;
    rx_data = 1'b0;
    rx_low = 1'b0;
    rx_los = 1'b0;
  end
  assign line_bits = LINE_BITS;
  assign level = LEVEL_CODE;
  // Loopback one slot late; idle data toggles
  always @(posedge clk) begin
    slot_d <= tx_slot;
    rx_slot <= slot_d;
    rx_data <= slot_d ? (tx_data ^ inj_err) : ~rx_data;
    rx_low <= los_req;
    rx_los <= los_req;
  end
endmodule : sptu_line_model

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  import sptu_pkg::*;
  localparam int SEC = 100;
  logic REF_CLK = 1'b0, SYS_RST = 1'b1, WR = 1'b0, RD = 1'b0, TX_SLOT = 1'b0;
  logic [9:0] ADDR = '0;
  logic [31:0] WDATA = '0, RDATA, uword;
  logic TX_DATA, RX_SLOT, RX_DATA, RX_LOW, RX_LOS, IRQ, fb;
  logic [7:0] RX_LINE_BITS;
  logic [15:0] RX_LEVEL;
  logic inj = 1'b0, los_req = 1'b0, rd_p = 1'b0, tx_p = 1'b0;
  logic [13:0] p1cfg = 14'h0000;
  int ulen = 32;
  logic [30:0] lfsr;
  logic [34:0] dev;
  logic [31:0] exp_rd[$];
  logic exp_tx[$];
  logic [7:0] pats [8] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h55, 8'h88, 8'h80, 8'h42};
  int n_mismatch = 0, check_count = 0, cycles = 0;
  integer seed = 32'h3d59b75f;
  localparam logic [31:0] RXON = 32'h1 << F_RXON;

  sptu_top #(.SEC_CYCLES_P(SEC)) i_dut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .TX_SLOT(TX_SLOT), .TX_DATA(TX_DATA), .RX_SLOT(RX_SLOT),
    .RX_DATA(RX_DATA), .RX_LINE_BITS(RX_LINE_BITS), .RX_LEVEL(RX_LEVEL), .RX_LOW(RX_LOW),
    .RX_LOS(RX_LOS), .P1_RXCFG(p1cfg), .IRQ(IRQ));
  sptu_line_model i_line (.clk(REF_CLK), .tx_slot(TX_SLOT), .tx_data(TX_DATA), .inj_err(inj),
    .los_req(los_req), .rx_slot(RX_SLOT), .rx_data(RX_DATA), .line_bits(RX_LINE_BITS),
    .level(RX_LEVEL), .rx_low(RX_LOW), .rx_los(RX_LOS));

  initial begin
    forever #25 REF_CLK = ~REF_CLK;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] cfg(input logic [2:0] t, input logic [4:0] o, input logic inv,
                                      input logic [2:0] c, input logic [1:0] tc);
    return (32'(t) << F_TYPE) | (32'(o) << F_ORD) | (32'(inv) << F_INV) | (32'(c) << F_CONT) | (32'(tc) << F_TCM);
  endfunction : cfg

  // One register cycle; a read notes its expected word
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    WR <= w;
    RD <= !w;
    ADDR <= a;
    WDATA <= d;
    if (!w) exp_rd.push_back(d);
  endtask : bus

  task automatic idle(input int n);
    @(posedge REF_CLK);
    WR <= 1'b0;
    RD <= 1'b0;
    repeat (n) @(posedge REF_CLK);
  endtask : idle

  task automatic chk_irq(input logic e);
    @(negedge REF_CLK);
    chk({31'h0, IRQ}, {31'h0, e});
  endtask : chk_irq

  task automatic do_reset();
    @(posedge REF_CLK);
    SYS_RST <= 1'b1;
    WR <= 1'b0;
    RD <= 1'b0;
    repeat (5) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
  endtask : do_reset

  // Slots with expected bits: 0 fixed byte, 1 user word, 2 random slots of inverted PRBS9
  task automatic send(input int n, input int kind, input logic [7:0] pat);
    logic s;
    logic b;
    logic [31:0] w;
    for (int i = 0; i < n; i++) begin
      @(posedge REF_CLK);
      WR <= 1'b0;
      RD <= 1'b0;
      s = (kind == 2) ? 1'($random(seed)) : 1'b1;
      TX_SLOT <= s;
      if (s) begin
        if (kind == 0) b = pat[7 - i % 8];
        else if (kind == 1) begin
          w = uword ^ 32'((i % ulen) / 32);
          b = w[i % 32];
        end
        else begin
          fb = lfsr[8] ^ lfsr[4];
          lfsr = {lfsr[29:0], fb};
          b = ~fb;
        end
        exp_tx.push_back(b);
      end
    end
    @(posedge REF_CLK);
    TX_SLOT <= 1'b0;
  endtask : send

  always @(posedge REF_CLK) begin
    rd_p <= RD;
    tx_p <= TX_SLOT;
    cycles++;
    if (cycles == 12000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // Result watcher
  always @(negedge REF_CLK) begin
    if (rd_p) chk(RDATA, exp_rd.pop_front());
    if (tx_p && exp_tx.size() > 0) chk({31'h0, TX_DATA}, {31'h0, exp_tx.pop_front()});
  end

  initial begin
    repeat (5) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    bus(0, A_TXCFG, RST_TXCFG);
    bus(0, A_RXCFG, RST_RXCFG);
    bus(0, A_MASK, 32'h0);
    bus(0, 10'h0F0, 32'h0);
    bus(1, A_TXCFG, 32'h80000000 | cfg(3'h0, 5'h00, 1'b0, C_C3VC4, 2'h0));
    bus(0, A_TXCFG, cfg(PT_PRBS, ORD_VC4, 1'b1, C_C3VC4, 2'h0));
    bus(1, A_TXCFG, 32'h80000000 | cfg(3'h0, 5'h00, 1'b0, C_C12, 2'h0));
    bus(0, A_TXCFG, cfg(PT_PRBS, ORD_LO, 1'b1, C_C12, 2'h0));
    bus(1, A_RXCFG, RXON | cfg(3'h0, 5'h00, 1'b0, C_C4, TCM_N1VC3));
    bus(0, A_RXCFG, RXON | cfg(3'h0, 5'h00, 1'b0, C_C3VC3, TCM_N1VC3));
    bus(1, A_RXCFG, RXON | cfg(3'h0, 5'h00, 1'b0, C_C4, TCM_N2));
    bus(0, A_RXCFG, RXON | cfg(3'h0, 5'h00, 1'b0, C_C12, TCM_N2));
    for (int k = 2; k < 8; k++) begin
      do_reset();
      bus(1, A_TXCFG, 32'(k));
      send(8, 0, pats[k]);
    end
    do_reset();
    uword = $random(seed);
    bus(1, 10'h100, uword);
    bus(1, A_TXCFG, 32'h0);
    send(40, 1, 8'h00);
    do_reset();
    for (int j = 0; j < 64; j++) bus(1, 10'h100 + 10'(4 * j), uword ^ 32'(j));
    bus(0, 10'h1FC, uword ^ 32'h0000003F);
    bus(1, A_USRLEN, 32'h1);
    bus(0, A_USRLEN, 32'h1);
    bus(1, A_TXCFG, 32'h0);
    ulen = 2048;
    send(2080, 1, 8'h00);
    do_reset();
    bus(1, A_TXCFG, cfg(PT_PRBS, 5'h09, 1'b1, C_C4, 2'h0));
    bus(1, A_RXCFG, RXON | cfg(PT_PRBS, 5'h09, 1'b1, C_C4, 2'h0));
    bus(1, A_MASK, 32'h1);
    lfsr = PRBS_SEED;
    send(400, 2, 8'h00);
    bus(0, A_ERRCNT, 32'h0);
    idle(1);
    chk_irq(1'b0);
    @(posedge REF_CLK);
    TX_SLOT <= 1'b1;
    repeat (20) @(posedge REF_CLK);
    inj <= 1'b1;
    @(posedge REF_CLK);
    inj <= 1'b0;
    repeat (30) @(posedge REF_CLK);
    TX_SLOT <= 1'b0;
    chk_irq(1'b1);
    bus(0, A_ERRCNT, 32'h3);
    bus(1, A_STAT, 32'hF);
    idle(2);
    chk_irq(1'b0);
    do_reset();
    bus(1, A_RXCFG, RST_RXCFG | (32'h1 << F_RATE));
    bus(1, A_MASK, 32'h1 << S_LOS);
    bus(1, A_STAT, 32'hF);
    idle(0);
    TX_SLOT <= 1'b1;
    repeat (310) @(posedge REF_CLK);
    dev = 35'(SEC * 8) - NOM_STM4;
    bus(0, A_RATE_LO, 32'(SEC * 8));
    bus(0, A_RATE_HI, 32'h0);
    bus(0, A_DEV, dev[31:0]);
    bus(0, A_PATRATE, 32'(SEC));
    idle(1);
    chk_irq(1'b0);
    @(posedge REF_CLK);
    los_req <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    chk_irq(1'b1);
    bus(0, A_LEVEL, 32'h00021234);
    bus(1, A_MASK, 32'h0);
    idle(2);
    chk_irq(1'b0);
    bus(1, A_MASK, 32'h1 << S_LOS);
    idle(2);
    chk_irq(1'b1);
    bus(1, A_STAT, 32'h1 << S_LOS);
    idle(2);
    chk_irq(1'b0);
    bus(1, A_RXCFG, RXON | (32'h1 << F_PORT2) | (32'(FOL_RX1) << F_FOL));
    p1cfg <= 14'(cfg(PT_ZERO, 5'h09, 1'b1, C_C4, TCM_N1VC3));
    bus(0, A_EFFRX, RXON | (32'h1 << F_PORT2) | (32'(FOL_RX1) << F_FOL) |
        cfg(PT_ZERO, 5'h09, 1'b1, C_C3VC3, TCM_N1VC3));
    bus(1, A_RXCFG, RXON | (32'(FOL_RX1) << F_FOL) | cfg(PT_ONE, 5'h0F, 1'b0, C_C12, 2'h0));
    bus(0, A_EFFRX, RXON | (32'(FOL_RX1) << F_FOL) | cfg(PT_ONE, 5'h0F, 1'b0, C_C12, 2'h0));
    bus(1, A_RXCFG, RXON | (32'(FOL_TX) << F_FOL));
    bus(0, A_EFFRX, RXON | (32'(FOL_TX) << F_FOL) | RST_TXCFG);
    bus(1, A_RXCFG, 32'h0);
    for (int a = 0; a < 5; a++) bus(0, A_RATE_LO + 10'(4 * a), NA_VAL);
    idle(2);
    report_and_stop();
  end
endmodule : testbench
